// >>> zqc_host.sv
// Notes on behaviour
// - Entry-then-exit overlap: treat termination response uncertain
// - Exit-then-entry overlap: treat termination response uncertain
// - Long calibration usable at init and later
// - Device calibrates, then loads driver and termination
// - First long gets init window, later shorter
// - Short calibration finishes within its window
// - Space short calibrations by drift-derived interval; left to the requester, not enforced here
// - No other commands during calibration windows
// - Device cuts resistor current after calibration
// - All banks precharged, precharge time met first
// - Calibration no sooner than exit time after self-refresh
// - No self-started calibration at self refresh exit
// - Shared resistor: rank windows never overlap
// - Clock enable held high throughout calibration
// - Termination pin held low during calibration
// - Data pins released during calibration
// - Refresh recovery time before activate or refresh
// - Entry transition starts write latency less one early
// - Exit transition spans before and after clock enable
module zqc_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire zqc_pkg::zqc_op_t req_op,
  output logic req_ready,
  input wire logic user_odt,
  input wire logic user_dq_oe,
  input wire logic zq_peer_busy,
  output logic zq_busy,
  output logic odt_uncertain,
  zqc_link_if.host link
);
  // ----------------------------------------
  // State and helpers
  // ----------------------------------------
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_PREP = 3'b010,
    H_WAIT = 3'b100
  } zqc_hst_t;

  function automatic logic is_pd(input zqc_pkg::zqc_op_t op);
    is_pd = (op == zqc_pkg::OP_PDE) || (op == zqc_pkg::OP_PDX);
  endfunction

  zqc_hst_t state;
  zqc_pkg::zqc_op_t held_op;
  logic [2:0] div_cnt;
  logic [2:0] next_div_cnt;
  logic tick;
  logic [zqc_pkg::TMR_W-1:0] tmr;
  logic [zqc_pkg::TMR_W-1:0] rp_cnt;
  logic banks_open;
  logic zq_first_done;
  logic peer_s1;
  logic peer_s2;
  logic zq_want;
  localparam logic [zqc_pkg::TMR_W-1:0] TMR_W_RFC = zqc_pkg::TMR_W'(zqc_pkg::RFC_NCK);

  assign next_div_cnt = div_cnt + 3'h1;
  // Commands change on the falling link edge, mid-way between samples
  assign tick = (div_cnt == 3'h7);
  assign zq_want = req_valid && (req_op == zqc_pkg::OP_ZQL || req_op == zqc_pkg::OP_ZQS);

  // ----------------------------------------
  // Link clock divider
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 3'h0;
      link.ck <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      link.ck <= next_div_cnt[2];
    end
  end

  // ----------------------------------------
  // Peer rank busy synchroniser
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      peer_s1 <= 1'b0;
      peer_s2 <= 1'b0;
    end else begin
      peer_s1 <= zq_peer_busy;
      peer_s2 <= peer_s1;
    end
  end

  // ----------------------------------------
  // Termination and data pins
  // ----------------------------------------
  // Forced off as soon as a calibration is wanted, no later than the command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.odt <= 1'b0;
      link.dq_oe_host <= 1'b0;
    end else begin
      link.odt <= user_odt && !zq_busy && !zq_want;
      link.dq_oe_host <= user_dq_oe && !zq_busy && !zq_want;
    end
  end

  // ----------------------------------------
  // Precharge recovery counter
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rp_cnt <= '0;
    end else if (tick) begin
      if (state == H_IDLE && req_valid && link.cke &&
          req_op == zqc_pkg::OP_PREA) begin
        rp_cnt <= zqc_pkg::RP_NCK;
      end else if (state == H_IDLE && zq_want && banks_open) begin
        rp_cnt <= zqc_pkg::RP_NCK;
      end else if (rp_cnt != '0) begin
        rp_cnt <= rp_cnt - 10'h001;
      end
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= H_IDLE;
      held_op <= zqc_pkg::OP_ZQL;
      tmr <= '0;
      banks_open <= 1'b0;
      zq_first_done <= 1'b0;
      zq_busy <= 1'b0;
      odt_uncertain <= 1'b0;
      req_ready <= 1'b0;
      link.cke <= 1'b1;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= zqc_pkg::CMD_NOP;
      link.a10 <= 1'b0;
    end else begin
      req_ready <= 1'b0;
      if (tick) begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= zqc_pkg::CMD_NOP;
        link.a10 <= 1'b0;
        case (state)
          H_IDLE: begin
            if (req_valid) begin
              case (req_op)
                zqc_pkg::OP_ZQL, zqc_pkg::OP_ZQS: begin
                  if (banks_open) begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= zqc_pkg::CMD_PRE;
                    link.a10 <= 1'b1;
                    banks_open <= 1'b0;
                  end else if (rp_cnt == '0 && !peer_s2 && link.cke) begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= zqc_pkg::CMD_ZQ;
                    link.a10 <= (req_op == zqc_pkg::OP_ZQL);
                    zq_busy <= 1'b1;
                    req_ready <= 1'b1;
                    state <= H_WAIT;
                    // Short calibration spacing is the requester's job
                    if (req_op == zqc_pkg::OP_ZQS) begin
                      tmr <= zqc_pkg::ZQCS_NCK;
                    end else begin
                      zq_first_done <= 1'b1;
                      tmr <= zq_first_done ? zqc_pkg::ZQOPER_NCK
                                           : zqc_pkg::ZQINIT_NCK;
                    end
                  end
                end
                zqc_pkg::OP_ACT: begin
                  if (rp_cnt == '0 && link.cke) begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= zqc_pkg::CMD_ACT;
                    banks_open <= 1'b1;
                    req_ready <= 1'b1;
                    tmr <= zqc_pkg::ACT_GAP_NCK;
                    state <= H_WAIT;
                  end
                end
                zqc_pkg::OP_PREA: begin
                  // No precharge while the clock enable is low
                  if (link.cke) begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= zqc_pkg::CMD_PRE;
                    link.a10 <= 1'b1;
                    banks_open <= 1'b0;
                    req_ready <= 1'b1;
                  end
                end
                zqc_pkg::OP_REF, zqc_pkg::OP_SRE: begin
                  if (!banks_open && rp_cnt == '0 && link.cke) begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= zqc_pkg::CMD_REF;
                    link.cke <= (req_op == zqc_pkg::OP_REF);
                    req_ready <= 1'b1;
                    tmr <= TMR_W_RFC;
                    state <= H_WAIT;
                  end
                end
                zqc_pkg::OP_SRX: begin
                  link.cke <= 1'b1;
                  req_ready <= 1'b1;
                  tmr <= zqc_pkg::XS_NCK;
                  state <= H_WAIT;
                end
                zqc_pkg::OP_PDE, zqc_pkg::OP_PDX: begin
                  held_op <= req_op;
                  odt_uncertain <= 1'b1;
                  tmr <= zqc_pkg::ANPD_NCK;
                  state <= H_PREP;
                end
                default: req_ready <= 1'b0;
              endcase
            end
          end
          H_PREP: begin
            tmr <= tmr - 10'h001;
            if (tmr == 10'h001) begin
              link.cke <= (held_op == zqc_pkg::OP_PDX);
              req_ready <= 1'b1;
              tmr <= (held_op == zqc_pkg::OP_PDX) ? zqc_pkg::XPDLL_NCK
                                                  : zqc_pkg::CPDED_NCK;
              state <= H_WAIT;
            end
          end
          H_WAIT: begin
            tmr <= tmr - 10'h001;
            if (tmr <= 10'h001) begin
              zq_busy <= 1'b0;
              // Back-to-back transitions keep the flag up over the overlap
              odt_uncertain <= req_valid && is_pd(req_op);
              state <= H_IDLE;
            end
          end
          default: state <= H_IDLE;
        endcase
      end
    end
  end

endmodule

// >>> zqc_pkg.sv
package zqc_pkg;
  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int CORE_PERIOD_NS = 8;
  localparam int CK_DIV = 8;
  localparam int CK_PERIOD_NS = CORE_PERIOD_NS * CK_DIV;
  localparam int TMR_W = 10;

  // ----------------------------------------
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_ACT = 4'h3;

  // ----------------------------------------
  // Timing, in link clock cycles unless named _NS
  // ----------------------------------------
  localparam logic [TMR_W-1:0] ZQINIT_NCK = 10'h200;
  localparam logic [TMR_W-1:0] ZQOPER_NCK = 10'h100;
  localparam logic [TMR_W-1:0] ZQCS_NCK = 10'h040;
  localparam int RFC_NS = 260;
  localparam int RFC_NCK = (RFC_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam logic [TMR_W-1:0] RP_NCK = 10'h00b;
  localparam logic [TMR_W-1:0] XS_NCK = 10'h00a;
  localparam logic [TMR_W-1:0] XPDLL_NCK = 10'h00a;
  localparam logic [TMR_W-1:0] CPDED_NCK = 10'h002;
  localparam logic [TMR_W-1:0] WL_NCK = 10'h005;
  localparam logic [TMR_W-1:0] ANPD_NCK = WL_NCK - 10'h001;
  localparam logic [TMR_W-1:0] ACT_GAP_NCK = 10'h002;

  // ----------------------------------------
  // Impedance code
  // ----------------------------------------
  localparam int CODE_W = 6;
  localparam logic [CODE_W-1:0] CODE_RST = 6'h20;
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h3f;
  localparam logic [CODE_W-1:0] CODE_MIN = 6'h00;

  typedef enum logic [3:0] {
    OP_ZQL = 4'h0,
    OP_ZQS = 4'h1,
    OP_ACT = 4'h2,
    OP_PREA = 4'h3,
    OP_REF = 4'h4,
    OP_SRE = 4'h5,
    OP_SRX = 4'h6,
    OP_PDE = 4'h7,
    OP_PDX = 4'h8
  } zqc_op_t;
endpackage

// >>> zqc_link_if.sv
interface zqc_link_if;
  logic ck;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic a10;
  logic odt;
  logic dq_oe_host;
  logic dq_oe_dev;

  modport host (
    output ck, cke, cs_n, ras_n, cas_n, we_n, a10, odt, dq_oe_host,
    input dq_oe_dev
  );
  modport dev (
    input ck, cke, cs_n, ras_n, cas_n, we_n, a10, odt, dq_oe_host,
    output dq_oe_dev
  );
endinterface

// >>> zqc_dev.sv
module zqc_dev (
  zqc_link_if.dev link,
  input wire logic rst,
  input wire logic zq_cmp,
  output logic [zqc_pkg::CODE_W-1:0] ron_code,
  output logic [zqc_pkg::CODE_W-1:0] rtt_code,
  output logic zq_cur_en,
  output logic cal_busy
);
  // ----------------------------------------
  // Types and helpers
  // ----------------------------------------
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_CAL = 3'b010,
    D_XFER = 3'b100
  } zqc_dst_t;

  function automatic logic [zqc_pkg::CODE_W-1:0] step(
    input logic [zqc_pkg::CODE_W-1:0] c, input logic up);
    if (up) begin
      step = (c == zqc_pkg::CODE_MAX) ? c : c + 6'h01;
    end else begin
      step = (c == zqc_pkg::CODE_MIN) ? c : c - 6'h01;
    end
  endfunction

  zqc_dst_t state;
  logic [zqc_pkg::TMR_W-1:0] cnt;
  logic [zqc_pkg::CODE_W-1:0] code;
  logic first_done;
  logic cmp_s1;
  logic cmp_s2;
  logic is_zq;

  // Commands are launched on the far clock edge, so they are stable here
  assign is_zq = link.cke && ({link.cs_n, link.ras_n, link.cas_n, link.we_n}
                              == zqc_pkg::CMD_ZQ);

  // ----------------------------------------
  // Comparator synchroniser
  // ----------------------------------------
  always_ff @(posedge link.ck or posedge rst) begin
    if (rst) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      cmp_s1 <= zq_cmp;
      cmp_s2 <= cmp_s1;
    end
  end

  // ----------------------------------------
  // Calibration engine
  // ----------------------------------------
  // Self refresh exit is not decoded: only a calibration command starts one
  always_ff @(posedge link.ck or posedge rst) begin
    if (rst) begin
      state <= D_IDLE;
      cnt <= '0;
      code <= zqc_pkg::CODE_RST;
      first_done <= 1'b0;
      ron_code <= zqc_pkg::CODE_RST;
      rtt_code <= zqc_pkg::CODE_RST;
      zq_cur_en <= 1'b0;
      cal_busy <= 1'b0;
    end else begin
      case (state)
        D_IDLE: begin
          if (is_zq) begin
            zq_cur_en <= 1'b1;
            cal_busy <= 1'b1;
            state <= D_CAL;
            if (link.a10) begin
              first_done <= 1'b1;
              cnt <= (first_done ? zqc_pkg::ZQOPER_NCK : zqc_pkg::ZQINIT_NCK)
                     - 10'h002;
            end else begin
              cnt <= zqc_pkg::ZQCS_NCK - 10'h002;
            end
          end
        end
        D_CAL: begin
          // One code step per clock: a 64-clock short window moves the code by up to 63 steps
          code <= step(code, cmp_s2);
          cnt <= cnt - 10'h001;
          if (cnt == '0) begin
            state <= D_XFER;
          end
        end
        D_XFER: begin
          ron_code <= code;
          rtt_code <= code;
          zq_cur_en <= 1'b0;
          cal_busy <= 1'b0;
          state <= D_IDLE;
        end
        default: state <= D_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Data bus
  // ----------------------------------------
  // No read path here, so the data pins never drive
  always_ff @(posedge link.ck or posedge rst) begin
    if (rst) begin
      link.dq_oe_dev <= 1'b0;
    end else begin
      link.dq_oe_dev <= 1'b0;
    end
  end
endmodule

// >>> zqc_link_sva.sv
module zqc_link_sva (
  input wire logic ck,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  input wire logic odt,
  input wire logic dq_oe_host,
  input wire logic dq_oe_dev
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Window trackers
  // ----------------
  logic [3:0] cmd;
  logic [9:0] win;
  logic [9:0] quiet;
  logic [9:0] rp;
  logic [9:0] xs;
  int rfc;
  logic zq;
  logic zql_seen;
  logic open;
  logic in_sr;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign zq = cmd == zqc_pkg::CMD_ZQ;
  // Only the first long command after reset gets the init window
  assign win = a10 ? (zql_seen ? zqc_pkg::ZQOPER_NCK : zqc_pkg::ZQINIT_NCK) : zqc_pkg::ZQCS_NCK;
  always_ff @(posedge ck or posedge rst) begin
    if (rst) quiet <= '0;
    else if (zq) quiet <= win - 10'h001;
    else if (quiet != 0) quiet <= quiet - 10'h001;
  end
  always_ff @(posedge ck or posedge rst) begin
    if (rst) zql_seen <= 1'b0;
    else if (zq && a10) zql_seen <= 1'b1;
  end
  always_ff @(posedge ck or posedge rst) begin
    if (rst) open <= 1'b0;
    else if (cmd == zqc_pkg::CMD_ACT) open <= 1'b1;
    else if (cmd == zqc_pkg::CMD_PRE && a10) open <= 1'b0;
  end
  always_ff @(posedge ck or posedge rst) begin
    if (rst) rp <= '0;
    else if (cmd == zqc_pkg::CMD_PRE) rp <= zqc_pkg::RP_NCK - 10'h001;
    else if (rp != 0) rp <= rp - 10'h001;
  end
  always_ff @(posedge ck or posedge rst) begin
    if (rst) rfc <= 0;
    else if (cmd == zqc_pkg::CMD_REF && cke) rfc <= zqc_pkg::RFC_NCK - 1;
    else if (rfc != 0) rfc <= rfc - 1;
  end
  // Exit counted from the first edge that sees the clock enable high again
  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      in_sr <= 1'b0;
      xs <= '0;
    end else if (cmd == zqc_pkg::CMD_REF && !cke) begin
      in_sr <= 1'b1;
    end else if (in_sr && cke) begin
      in_sr <= 1'b0;
      xs <= zqc_pkg::XS_NCK - 10'h001;
    end else if (xs != 0) begin
      xs <= xs - 10'h001;
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge ck); endclocking
  default disable iff (rst);
  AST_QUIET_CMD: assert property (quiet != 0 |-> cmd == zqc_pkg::CMD_NOP)
    else $error("command issued inside calibration window");
  AST_QUIET_CKE: assert property (zq || quiet != 0 |-> cke && $past(cke))
    else $error("clock enable low during calibration");
  AST_QUIET_ODT: assert property (zq || quiet != 0 |-> !odt)
    else $error("termination pin high during calibration");
  AST_QUIET_DQ: assert property (zq || quiet != 0 |-> !dq_oe_host && !dq_oe_dev)
    else $error("data pins driven during calibration");
  AST_ZQ_BANKS: assert property (zq |-> !open)
    else $error("calibration with a bank open");
  AST_ZQ_RP: assert property (zq |-> rp == 0)
    else $error("calibration before precharge time");
  AST_REF_RFC: assert property (cmd == zqc_pkg::CMD_ACT || cmd == zqc_pkg::CMD_REF |-> rfc == 0)
    else $error("activate or refresh inside refresh recovery");
  AST_ZQ_XS: assert property (zq |-> xs == 0 && !in_sr)
    else $error("calibration too soon after self refresh exit");
  cover property (zq && a10);
  cover property (zq && !a10);
  cover property ($fell(cke) ##[1:40] $rose(cke));
  cover property (in_sr && cke);
endmodule

// >>> tb_top.sv
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, rst_dev = 1, req_valid = 0, user_odt = 1, user_dq_oe = 1;
  logic zq_peer_busy = 0, zq_cmp = 1, ok, req_ready, zq_busy, odt_uncertain, zq_cur_en, cal_busy;
  logic [zqc_pkg::CODE_W-1:0] ron_code, rtt_code;
  zqc_pkg::zqc_op_t req_op = zqc_pkg::OP_ZQL;
  int err_count = 0, samples_checked = 0, n;
  zqc_link_if link ();
  zqc_host zqc_host_inst (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req_op(req_op), .req_ready(req_ready), .user_odt(user_odt), .user_dq_oe(user_dq_oe),
    .zq_peer_busy(zq_peer_busy), .zq_busy(zq_busy), .odt_uncertain(odt_uncertain),
    .link(link.host));
  zqc_dev zqc_dev_inst (.link(link.dev), .rst(rst_dev), .zq_cmp(zq_cmp), .ron_code(ron_code),
    .rtt_code(rtt_code), .zq_cur_en(zq_cur_en), .cal_busy(cal_busy));
  zqc_link_sva zqc_link_sva_inst (.ck(link.ck), .rst(rst), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .a10(link.a10), .odt(link.odt),
    .dq_oe_host(link.dq_oe_host), .dq_oe_dev(link.dq_oe_dev));
  always #4 core_clk = ~core_clk;
  // ----------------
  // Drivers
  // ----------------
  task end_of_test;
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Refused requests stay pending so the next call keeps holding them
  task req(input zqc_pkg::zqc_op_t op, input int lim);
    ok = 0;
    req_op = op;
    req_valid = 1;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge core_clk);
      ok = req_ready;
    end
    if (ok) req_valid = 0;
  endtask
  task cal(input logic [9:0] w);
    `CHK("odt_off", 1'b0, link.odt)
    `CHK("dq_off", 1'b0, link.dq_oe_host)
    for (int i = 0; i < 64 && cal_busy !== 1'b1; i++) @(negedge link.ck);
    `CHK("cur_on", 1'b1, zq_cur_en)
    n = 0;
    while (cal_busy === 1'b1 && n < 1000) begin
      @(negedge link.ck);
      n++;
    end
    @(negedge core_clk);
    `CHK("cal_len", int'(w), n)
    `CHK("cur_off", 1'b0, zq_cur_en)
    `CHK("busy_end", 1'b0, zq_busy)
    `CHK("odt_back", user_odt, link.odt)
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task t_zql_first;
    req(zqc_pkg::OP_ZQL, 40);
    `CHK("zql_ok", 1'b1, ok)
    `CHK("zq_busy", 1'b1, zq_busy)
    cal(zqc_pkg::ZQINIT_NCK);
    `CHK("ron_up", 6'h3f, ron_code)
    `CHK("rtt_up", 6'h3f, rtt_code)
  endtask
  task t_zqs;
    zq_cmp = 0;
    req(zqc_pkg::OP_ZQS, 40);
    `CHK("zqs_ok", 1'b1, ok)
    cal(zqc_pkg::ZQCS_NCK);
    `CHK("rtt_down", 1'b1, rtt_code < 6'h3f)
  endtask
  task t_ref_act;
    req(zqc_pkg::OP_REF, 40);
    `CHK("ref_ok", 1'b1, ok)
    @(negedge core_clk);
    req(zqc_pkg::OP_ACT, 200);
    `CHK("act_ok", 1'b1, ok)
    @(negedge core_clk);
    req(zqc_pkg::OP_PREA, 40);
    `CHK("prea_ok", 1'b1, ok)
    @(negedge core_clk);
    req(zqc_pkg::OP_ZQS, 64);
    `CHK("zq_rp_held", 1'b0, ok)
    req(zqc_pkg::OP_ZQS, 200);
    `CHK("zq_rp_go", 1'b1, ok)
    cal(zqc_pkg::ZQCS_NCK);
    req(zqc_pkg::OP_ACT, 200);
    `CHK("act_reopen", 1'b1, ok)
  endtask
  task t_zql_open;
    zq_cmp = 1;
    req(zqc_pkg::OP_ZQL, 400);
    `CHK("zql2_ok", 1'b1, ok)
    cal(zqc_pkg::ZQOPER_NCK);
  endtask
  task t_self_refresh;
    req(zqc_pkg::OP_SRE, 200);
    `CHK("sre_ok", 1'b1, ok)
    repeat (40) @(negedge core_clk);
    req(zqc_pkg::OP_SRX, 200);
    repeat (100) @(negedge core_clk);
    `CHK("no_self_cal", 1'b0, cal_busy)
    req(zqc_pkg::OP_ZQS, 300);
    `CHK("zqs_sr_ok", 1'b1, ok)
    cal(zqc_pkg::ZQCS_NCK);
  endtask
  task t_peer;
    zq_peer_busy = 1;
    req(zqc_pkg::OP_ZQS, 200);
    `CHK("peer_held", 1'b0, ok)
    `CHK("peer_idle", 1'b0, zq_busy)
    zq_peer_busy = 0;
    req(zqc_pkg::OP_ZQS, 200);
    `CHK("peer_go", 1'b1, ok)
    cal(zqc_pkg::ZQCS_NCK);
  endtask
  // Exit requested at once so entry and exit periods overlap
  task t_power_down;
    req(zqc_pkg::OP_PDE, 200);
    `CHK("pde_unc", 1'b1, odt_uncertain)
    `CHK("pde_cke", 1'b0, link.cke)
    @(negedge core_clk);
    req(zqc_pkg::OP_PDX, 200);
    `CHK("pdx_unc", 1'b1, odt_uncertain)
    `CHK("pdx_cke", 1'b1, link.cke)
    repeat (200) @(negedge core_clk);
    `CHK("unc_end", 1'b0, odt_uncertain)
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    rst = 0;
    repeat (40) @(negedge core_clk);
    rst_dev = 0;
    repeat (16) @(negedge core_clk);
    t_zql_first();
    t_zqs();
    t_ref_act();
    t_zql_open();
    t_self_refresh();
    t_peer();
    t_power_down();
    end_of_test();
  end
  initial begin
    #200us;
    err_count++;
    end_of_test();
  end
endmodule
